/* File: src/ishs_pkg.sv */
package ishs_pkg;

  // --------------------------------------------------------------------
  // Address matching
  // --------------------------------------------------------------------
  localparam logic [7:0] ISHS_GEN_CALL_ADDR = 8'h00;
  localparam logic [4:0] ISHS_TEN_BIT_PREFIX = 5'h1e;

  // --------------------------------------------------------------------
  // Values after reset
  // --------------------------------------------------------------------
  localparam logic [7:0] ISHS_ADDR_RESET = 8'h00;
  localparam logic [7:0] ISHS_TX_RESET = 8'hff;
  localparam logic ISHS_RELEASE_RESET = 1'b1;
  localparam logic ISHS_LINE_IDLE = 1'b1;

  // --------------------------------------------------------------------
  // Counts
  // --------------------------------------------------------------------
  localparam logic [3:0] ISHS_RX_BITS = 4'h8;
  localparam logic [3:0] ISHS_TX_LAST_BIT = 4'h7;
  localparam int ISHS_RX_DEPTH = 2;

  // --------------------------------------------------------------------
  // Bus sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK  = 5'h04,
    ST_SEND = 5'h08,
    ST_MACK = 5'h10
  } ishs_state_t;

endpackage

/* File: src/ishs_line_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ishs_line_sync
  import ishs_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic rstSyncN,
  input wire logic [WIDTH-1:0] lineIn,
  output logic [WIDTH-1:0] lineLevel,
  output logic [WIDTH-1:0] lineRise,
  output logic [WIDTH-1:0] lineFall
);

  if (WIDTH < 1) begin : g_bad_width
    $error("ishs_line_sync: WIDTH must be at least 1");
  end

  // ------------------------------------------------------------------
  // Two-stage synchroniser and edge finder per line
  // ------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_line
    logic meta;
    logic stable;
    logic prev;
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        meta <= ISHS_LINE_IDLE;
        stable <= ISHS_LINE_IDLE;
        prev <= ISHS_LINE_IDLE;
      end else begin
        meta <= lineIn[i];
        stable <= meta;
        prev <= stable;
      end
    end
    assign lineLevel[i] = stable;
    assign lineRise[i] = stable & ~prev;
    assign lineFall[i] = ~stable & prev;
  end

endmodule // ishs_line_sync
`default_nettype wire

/* File: src/ishs_pair_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ishs_pair_fifo
  import ishs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = ISHS_RX_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstSyncN,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_shape
    $error("ishs_pair_fifo: WIDTH >= 1 and DEPTH a power of two >= 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0] fill;
  logic push;
  logic pop;

  assign inReady = fill != (PTR_W + 1)'(DEPTH);
  assign outValid = fill != '0;
  assign outData = store[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wrPtr] <= inData;
    end
  end

  // ------------------------------------------------------------------
  // Pointers and fill level
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule // ishs_pair_fifo
`default_nettype wire

/* File: src/ishs_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Address hold: clear release, flag after 8th fall
// - Read request: clear release, flag after ack
// - Capture master ack on 9th pulse
// - Master not-ack: release bus, no stretch
// - 10-bit high byte write: update flag, ack, irq
// - Update flag stretches; address write releases
// - Low byte mismatch: irq, update flag, no full
// - Stretch enable: clear release after each ack
// - Stretch decision ignores buffer-full flag
// - Data hold: clear release after 8th fall
// - Hold clock only after sampling it low
// - Keep clock low until release bit set
// - General call acked regardless of own address
// - General call sets no update flag
// - General call also held under address hold
// - Ack timing, read/write, data/address flags
// - Start seen flag; irq only if enabled
// - Full set on load, cleared on read
module ishs_slave
  import ishs_pkg::*;
#(
  parameter int RX_DEPTH = ISHS_RX_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic tenBitMode,
  input wire logic addressHoldEnable,
  input wire logic dataHoldEnable,
  input wire logic stretchEnable,
  input wire logic generalCallEnable,
  input wire logic startIrqEnable,
  input wire logic ackValueSelect,
  input wire logic clockReleaseSet,
  input wire logic portIrqClear,
  input wire logic slaveAddrWrite,
  input wire logic [7:0] slaveAddrData,
  input wire logic txLoad,
  input wire logic [7:0] txData,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] slaveAddressReg,
  output logic clockReleaseBit,
  output logic portIrqFlag,
  output logic bufferFullFlag,
  output logic updateAddressFlag,
  output logic ackTimingFlag,
  output logic readWriteFlag,
  output logic dataAddressFlag,
  output logic receivedAckStatus,
  output logic startSeen,
  output logic stopSeen
);

  if (RX_DEPTH < 2) begin : g_bad_depth
    $error("ishs_slave: RX_DEPTH must be at least 2");
  end

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstSyncN;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // ------------------------------------------------------------------
  // Line sampling
  // ------------------------------------------------------------------
  logic [1:0] lineLevel;
  logic [1:0] lineRise;
  logic [1:0] lineFall;
  logic sclSync;
  logic sdaSync;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  ishs_line_sync #(
    .WIDTH(2)
  ) u_line_sync (
    .sys_clk(sys_clk),
    .rstSyncN(rstSyncN),
    .lineIn({sdaIn, sclIn}),
    .lineLevel(lineLevel),
    .lineRise(lineRise),
    .lineFall(lineFall)
  );

  assign sclSync = lineLevel[0];
  assign sdaSync = lineLevel[1];
  assign sclRise = lineRise[0];
  assign sclFall = lineFall[0];
  assign startCond = lineFall[1] && sclSync && !sclRise;
  assign stopCond = lineRise[1] && sclSync && !sclRise;

  // ------------------------------------------------------------------
  // Byte evaluation
  // ------------------------------------------------------------------
  ishs_state_t state;
  logic [3:0] bitCount;
  logic [7:0] shiftIn;
  logic [7:0] txShift;
  logic pendEval;
  logic firstByte;
  logic expectLow;
  logic tenAddressed;
  logic ackOk;
  logic holdByte;
  logic addrWaitHold;
  logic holdLow;
  logic sdaDrive;
  logic rxInReady;
  logic doEval;
  logic ackBit;
  logic ackFall;
  logic mackFall;
  logic hwClear;
  logic irqSet;
  logic stretchReq;
  logic evMatch;
  logic evPush;
  logic evHold;
  logic evSetUpd;
  logic evRead;
  logic evData;
  logic evNextLow;
  logic evTenDone;
  logic next_sdaDrive;

  always_comb begin
    evMatch = 1'b0;
    evPush = 1'b0;
    evHold = 1'b0;
    evSetUpd = 1'b0;
    evRead = 1'b0;
    evData = 1'b0;
    evNextLow = 1'b0;
    evTenDone = 1'b0;
    if (firstByte) begin
      if (generalCallEnable && shiftIn == ISHS_GEN_CALL_ADDR) begin
        evMatch = 1'b1;
      end else if (!tenBitMode) begin
        evMatch = shiftIn[7:1] == slaveAddressReg[7:1];
        evRead = shiftIn[0];
      end else if (shiftIn[7:3] == ISHS_TEN_BIT_PREFIX &&
                   shiftIn[2:1] == slaveAddressReg[2:1]) begin
        if (!shiftIn[0]) begin
          evMatch = 1'b1;
          evSetUpd = 1'b1;
          evNextLow = 1'b1;
        end else begin
          evMatch = tenAddressed;
          evRead = tenAddressed;
        end
      end
      evPush = evMatch;
      evHold = evMatch && addressHoldEnable;
    end else if (expectLow) begin
      evSetUpd = 1'b1;
      evMatch = shiftIn == slaveAddressReg;
      evTenDone = evMatch;
      evPush = evMatch;
      evHold = evMatch && addressHoldEnable;
    end else begin
      evData = 1'b1;
      evMatch = 1'b1;
      evPush = 1'b1;
      evHold = dataHoldEnable;
    end
  end

  assign doEval = (state == ST_RECV) && pendEval && rxInReady;
  assign ackBit = ackOk && !(holdByte && ackValueSelect);
  assign ackFall = (state == ST_ACK) && sclFall;
  assign mackFall = (state == ST_MACK) && sclFall;

  // ------------------------------------------------------------------
  // Received byte buffer
  // ------------------------------------------------------------------
  ishs_pair_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .rstSyncN(rstSyncN),
    .inValid(doEval && evPush),
    .inReady(rxInReady),
    .inData(shiftIn),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

  // ------------------------------------------------------------------
  // Bus sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state <= ST_IDLE;
      bitCount <= '0;
      shiftIn <= '0;
      pendEval <= 1'b0;
      firstByte <= 1'b0;
      expectLow <= 1'b0;
      tenAddressed <= 1'b0;
      readWriteFlag <= 1'b0;
      ackOk <= 1'b0;
      holdByte <= 1'b0;
    end else if (stopCond) begin
      state <= ST_IDLE;
      pendEval <= 1'b0;
      firstByte <= 1'b0;
      expectLow <= 1'b0;
      tenAddressed <= 1'b0;
    end else if (startCond) begin
      state <= ST_RECV;
      bitCount <= '0;
      pendEval <= 1'b0;
      firstByte <= 1'b1;
      expectLow <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          bitCount <= '0;
        end
        ST_RECV: begin
          if (doEval) begin
            pendEval <= 1'b0;
            firstByte <= 1'b0;
            expectLow <= evNextLow;
            tenAddressed <= tenAddressed | evTenDone;
            ackOk <= evMatch;
            holdByte <= evHold;
            if (firstByte) begin
              readWriteFlag <= evRead;
            end
            state <= ST_ACK;
          end else if (sclRise && bitCount < ISHS_RX_BITS) begin
            shiftIn <= {shiftIn[6:0], sdaSync};
            bitCount <= bitCount + 1'b1;
          end else if (sclFall && bitCount == ISHS_RX_BITS) begin
            pendEval <= 1'b1;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            bitCount <= '0;
            if (!ackBit) begin
              state <= ST_IDLE;
            end else if (readWriteFlag) begin
              state <= ST_SEND;
            end else begin
              state <= ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (sclFall) begin
            if (bitCount == ISHS_TX_LAST_BIT) begin
              bitCount <= '0;
              state <= ST_MACK;
            end else begin
              bitCount <= bitCount + 1'b1;
            end
          end
        end
        ST_MACK: begin
          if (sclFall) begin
            state <= receivedAckStatus ? ST_IDLE : ST_SEND;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Transmit shifter and data line drive
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      txShift <= ISHS_TX_RESET;
    end else if (txLoad) begin
      txShift <= txData;
    end else if (state == ST_SEND && sclFall) begin
      txShift <= {txShift[6:0], 1'b1};
    end
  end

  always_comb begin
    unique case (state)
      ST_ACK: next_sdaDrive = ackBit;
      ST_SEND: next_sdaDrive = !txShift[7];
      default: next_sdaDrive = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sdaDrive <= 1'b0;
    end else begin
      sdaDrive <= next_sdaDrive;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      receivedAckStatus <= 1'b0;
    end else if (state == ST_MACK && sclRise) begin
      receivedAckStatus <= sdaSync;
    end
  end

  // ------------------------------------------------------------------
  // Clock release bit and clock hold
  // ------------------------------------------------------------------
  assign hwClear = (doEval && evHold)
                || (ackFall && ackBit && (readWriteFlag || stretchEnable))
                || (mackFall && !receivedAckStatus);

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      clockReleaseBit <= ISHS_RELEASE_RESET;
    end else if (hwClear) begin
      clockReleaseBit <= 1'b0;
    end else if (clockReleaseSet) begin
      clockReleaseBit <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      addrWaitHold <= 1'b0;
    end else if (ackFall && updateAddressFlag) begin
      addrWaitHold <= 1'b1;
    end else if (slaveAddrWrite) begin
      addrWaitHold <= 1'b0;
    end
  end

  // Byte waiting for buffer space also holds the clock
  assign stretchReq = !clockReleaseBit || addrWaitHold || pendEval;

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      holdLow <= 1'b0;
    end else begin
      holdLow <= stretchReq && (holdLow || !sclSync);
    end
  end

  assign sclOe = holdLow;
  assign sclOut = 1'b0;
  assign sdaOe = sdaDrive;
  assign sdaOut = 1'b0;

  // ------------------------------------------------------------------
  // Software-facing flags
  // ------------------------------------------------------------------
  assign irqSet = (startCond && startIrqEnable)
               || (doEval && (evHold || expectLow))
               || (ackFall && ackBit)
               || mackFall;

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      portIrqFlag <= 1'b0;
    end else if (irqSet) begin
      portIrqFlag <= 1'b1;
    end else if (portIrqClear) begin
      portIrqFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      updateAddressFlag <= 1'b0;
    end else if (doEval && evSetUpd) begin
      updateAddressFlag <= 1'b1;
    end else if (slaveAddrWrite) begin
      updateAddressFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      bufferFullFlag <= 1'b0;
    end else if ((doEval && evPush) || txLoad) begin
      bufferFullFlag <= 1'b1;
    end else if ((rxValid && rxReady) ||
                 (state == ST_SEND && sclFall && bitCount == ISHS_TX_LAST_BIT)) begin
      bufferFullFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ackTimingFlag <= 1'b0;
      dataAddressFlag <= 1'b0;
    end else if (startCond || stopCond) begin
      ackTimingFlag <= 1'b0;
      dataAddressFlag <= 1'b0;
    end else if (doEval) begin
      ackTimingFlag <= 1'b1;
      dataAddressFlag <= evData;
    end else begin
      if (ackFall) begin
        ackTimingFlag <= 1'b0;
      end
      if (state == ST_SEND && sclFall && bitCount == ISHS_TX_LAST_BIT) begin
        dataAddressFlag <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      startSeen <= 1'b0;
      stopSeen <= 1'b0;
    end else if (startCond) begin
      startSeen <= 1'b1;
      stopSeen <= 1'b0;
    end else if (stopCond) begin
      startSeen <= 1'b0;
      stopSeen <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      slaveAddressReg <= ISHS_ADDR_RESET;
    end else if (slaveAddrWrite) begin
      slaveAddressReg <= slaveAddrData;
    end
  end

endmodule // ishs_slave
`default_nettype wire

/* File: dv/ishs_slave_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ishs_slave_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic stretchEnable,
  input wire logic startIrqEnable,
  input wire logic txLoad,
  input wire logic slaveAddrWrite,
  input wire logic clockReleaseBit,
  input wire logic portIrqFlag,
  input wire logic bufferFullFlag,
  input wire logic ackTimingFlag,
  input wire logic readWriteFlag,
  input wire logic dataAddressFlag,
  input wire logic receivedAckStatus,
  input wire logic startSeen
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // Bus events
  // ----------
  sequence start_s;
    sclIn && $past(sclIn) && $fell(sdaIn);
  endsequence
  sequence ack_end_s;
    $fell(ackTimingFlag) && $past(sdaOe);
  endsequence
  hold_keep_a: assert property (sclOe && !clockReleaseBit |=> sclOe)
    else $error("clock let go while release bit clear");
  oe_low_a: assert property ($rose(sclOe) |-> !$past(sclIn) && !$past(sclIn, 2))
    else $error("clock pulled before it was seen low");
  start_irq_a: assert property (start_s ##0 startIrqEnable |-> ##[1:6] startSeen && portIrqFlag)
    else $error("start not flagged");
  ack_irq_a: assert property (ack_end_s |-> portIrqFlag)
    else $error("no irq after ack");
  ack_stretch_a: assert property (
    ack_end_s ##0 (stretchEnable || readWriteFlag && !dataAddressFlag) |-> !clockReleaseBit)
    else $error("release bit not cleared after ack");
  nack_free_a: assert property (receivedAckStatus && readWriteFlag && dataAddressFlag |-> !sclOe)
    else $error("clock held after master nack");
  load_full_a: assert property (txLoad |=> bufferFullFlag)
    else $error("full flag not set on load");
  addr_release_a: assert property (slaveAddrWrite && clockReleaseBit && !stretchEnable |-> ##2 !sclOe)
    else $error("clock held after address write");
endmodule // ishs_slave_asserts
bind ishs_slave ishs_slave_asserts chk_u (.sys_clk, .rst_n, .sclIn, .sdaIn, .sclOe, .sdaOe,
  .stretchEnable, .startIrqEnable, .txLoad, .slaveAddrWrite, .clockReleaseBit, .portIrqFlag,
  .bufferFullFlag, .ackTimingFlag, .readWriteFlag, .dataAddressFlag, .receivedAckStatus,
  .startSeen);
`default_nettype wire

/* File: dv/ishs_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module ishs_bus_master (
  input wire logic sys_clk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclLow,
  output logic sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic hp();
    repeat (10) @(posedge sys_clk);
  endtask
  // Waits out a stretch by the slave, giving up after 3000 cycles
  task automatic wait_hi();
    int n;
    n = 0;
    while (!sclIn && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic bitx(input logic drv, output logic smp);
    sdaLow <= !drv;
    hp();
    sclLow <= 1'b0;
    wait_hi();
    hp();
    smp = sdaIn;
    sclLow <= 1'b1;
  endtask
  task automatic st();
    @(posedge sys_clk);
    sdaLow <= 1'b0;
    hp();
    sclLow <= 1'b0;
    wait_hi();
    hp();
    sdaLow <= 1'b1;
    hp();
    sclLow <= 1'b1;
  endtask
  task automatic sp();
    sdaLow <= 1'b1;
    hp();
    sclLow <= 1'b0;
    wait_hi();
    hp();
    sdaLow <= 1'b0;
    hp();
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], x);
    end
    bitx(1'b1, ack);
  endtask
  task automatic rd(input logic nack, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, b[i]);
    end
    bitx(nack, x);
  endtask
endmodule // ishs_bus_master
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ishs_pkg::*;
  localparam logic [7:0] A7 = 8'h5a;
  localparam logic [7:0] HI = 8'hf4;
  localparam logic [7:0] LO = 8'hc5;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tenBitMode, addressHoldEnable, dataHoldEnable, stretchEnable, generalCallEnable;
  logic startIrqEnable, ackValueSelect, clockReleaseSet, portIrqClear, slaveAddrWrite;
  logic txLoad, rxReady, rxValid, sclOe, sdaOe, sclLow, sdaLow, clockReleaseBit;
  logic portIrqFlag, bufferFullFlag, updateAddressFlag, ackTimingFlag, readWriteFlag;
  logic dataAddressFlag, receivedAckStatus, startSeen, stopSeen, stallRx, irqPrev, addrReq;
  logic [7:0] slaveAddrData, txData, rxData, slaveAddressReg, wantAddr, d;
  logic [7:0] expQ[$], txQ[$], expTx[$];
  int seed = 25, fail_count = 0, cmp_count = 0, cycles = 0, holdCnt = 0;
  wire logic sclW = !(sclLow || sclOe);
  wire logic sdaW = !(sdaLow || sdaOe);
  wire logic relGo = !clockReleaseBit && !clockReleaseSet && holdCnt >= 20;
  wire logic addrGo = updateAddressFlag && !ackTimingFlag && !slaveAddrWrite;
  always #4 sys_clk = ~sys_clk;
  ishs_slave dut_u (.sys_clk, .rst_n, .sclIn(sclW), .sclOut(), .sclOe, .sdaIn(sdaW),
    .sdaOut(), .sdaOe, .tenBitMode, .addressHoldEnable, .dataHoldEnable, .stretchEnable,
    .generalCallEnable, .startIrqEnable, .ackValueSelect, .clockReleaseSet, .portIrqClear,
    .slaveAddrWrite, .slaveAddrData, .txLoad, .txData, .rxData, .rxValid, .rxReady,
    .slaveAddressReg, .clockReleaseBit, .portIrqFlag, .bufferFullFlag, .updateAddressFlag,
    .ackTimingFlag, .readWriteFlag, .dataAddressFlag, .receivedAckStatus, .startSeen,
    .stopSeen);
  ishs_bus_master mst_u (.sys_clk, .sclIn(sclW), .sdaIn(sdaW), .sclLow, .sdaLow);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  task automatic cfg(input logic [5:0] c, input logic [7:0] a);
    @(posedge sys_clk);
    {tenBitMode, addressHoldEnable, dataHoldEnable, stretchEnable, generalCallEnable,
      startIrqEnable} <= c;
    wantAddr <= a;
    addrReq <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wb(input logic [7:0] b, input logic ea, input logic push);
    logic a;
    if (push) expQ.push_back(b);
    mst_u.wr(b, a);
    check(8'(a), 8'(ea), "ack");
  endtask
  // ----------
  // Software side and receive drain
  // ----------
  always @(posedge sys_clk) begin
    logic txGo;
    txGo = relGo && readWriteFlag && !ackTimingFlag && txQ.size() > 0;
    cycles++;
    irqPrev <= portIrqFlag;
    holdCnt <= clockReleaseBit ? 0 : holdCnt + 1;
    portIrqClear <= portIrqFlag && !portIrqClear;
    clockReleaseSet <= relGo;
    txLoad <= txGo;
    if (txGo) txData <= txQ.pop_front();
    slaveAddrWrite <= addrGo || (addrReq && !slaveAddrWrite);
    slaveAddrData <= addrGo ? (slaveAddressReg == HI ? LO : HI) : wantAddr;
    if (slaveAddrWrite) addrReq <= 1'b0;
    if (portIrqFlag && !irqPrev && ackTimingFlag)
      check(8'(clockReleaseBit), 8'(!(dataAddressFlag ? dataHoldEnable : addressHoldEnable)),
        "release");
    rxReady <= !stallRx && (($random(seed) & 3) != 0);
    if (rxValid === 1'b1 && rxReady)
      check(rxData, expQ.size() > 0 ? expQ.pop_front() : 8'hxx, "rxData");
    if (cycles == 60000) begin
      fail_count++;
      $display("ERROR timeout");
      finish_test();
    end
  end
  initial begin
    {tenBitMode, addressHoldEnable, dataHoldEnable, stretchEnable, generalCallEnable} = '0;
    {startIrqEnable, ackValueSelect, clockReleaseSet, portIrqClear, slaveAddrWrite} = '0;
    {txLoad, rxReady, stallRx, irqPrev, addrReq} = '0;
    {slaveAddrData, txData, wantAddr} = '0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check(8'(clockReleaseBit), 8'(ISHS_RELEASE_RESET), "reset release");
    check(slaveAddressReg, ISHS_ADDR_RESET, "reset address");
    // Plain write, receiver stalled until the buffer refuses
    cfg(6'b000001, A7);
    stallRx <= 1'b1;
    mst_u.st();
    check(8'(startSeen), 8'h01, "startSeen");
    fork
      begin
        wb(A7, 1'b0, 1'b1);
        for (int i = 0; i < 3; i++) wb(rnd(), 1'b0, 1'b1);
      end
      begin
        repeat (800) @(posedge sys_clk);
        check(8'(rxValid), 8'h01, "rxValid full");
        stallRx <= 1'b0;
      end
    join
    check(8'({readWriteFlag, dataAddressFlag}), 8'h01, "rw da");
    mst_u.sp();
    check(8'({startSeen, stopSeen}), 8'h01, "start stop");
    mst_u.st();
    wb(8'h20, 1'b1, 1'b0);
    mst_u.sp();
    $display("test 1 done");
    // Address and data hold with stretch, then general call
    cfg(6'b011110, A7);
    mst_u.st();
    wb(A7, 1'b0, 1'b1);
    wb(rnd(), 1'b0, 1'b1);
    // Let the held byte's ack slot close before choosing a nack
    repeat (8) @(posedge sys_clk);
    ackValueSelect <= 1'b1;
    wb(rnd(), 1'b1, 1'b1);
    mst_u.sp();
    @(posedge sys_clk) ackValueSelect <= 1'b0;
    mst_u.st();
    wb(ISHS_GEN_CALL_ADDR, 1'b0, 1'b1);
    wb(rnd(), 1'b0, 1'b1);
    mst_u.sp();
    $display("test 2 done");
    // Read with address hold
    cfg(6'b010000, A7);
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      txQ.push_back(d);
      expTx.push_back(d);
    end
    mst_u.st();
    wb(A7 | 8'h01, 1'b0, 1'b1);
    check(8'(readWriteFlag), 8'h01, "readWrite");
    for (int i = 0; i < 3; i++) begin
      mst_u.rd(i == 2, d);
      check(d, expTx.pop_front(), "tx byte");
      check(8'(receivedAckStatus), 8'(i == 2), "ack status");
    end
    mst_u.sp();
    $display("test 3 done");
    // Ten-bit addressing, mismatch and general call
    cfg(6'b100000, HI);
    mst_u.st();
    wb(HI, 1'b0, 1'b1);
    wb(LO, 1'b0, 1'b1);
    wb(rnd(), 1'b0, 1'b1);
    mst_u.sp();
    mst_u.st();
    wb(HI, 1'b0, 1'b1);
    wb(8'h33, 1'b1, 1'b0);
    mst_u.sp();
    check(slaveAddressReg, HI, "address back");
    cfg(6'b100010, HI);
    mst_u.st();
    wb(ISHS_GEN_CALL_ADDR, 1'b0, 1'b1);
    check(8'(updateAddressFlag), 8'h00, "update flag");
    wb(rnd(), 1'b0, 1'b1);
    mst_u.sp();
    $display("test 4 done");
    repeat (60) @(posedge sys_clk);
    check(8'(expQ.size()), 8'h00, "rx left");
    finish_test();
  end
endmodule // tb
`default_nettype wire
